// [core/autoneg_partner_ability_expansion_regs.sv]
`default_nettype none
module autoneg_partner_ability_expansion_regs
    import autoneg_regs_pkg::*;
#(
    parameter logic LOCAL_NP_ABLE = LOCAL_NP_ABLE_RESET
)
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // management register access
    input wire logic [ADDR_W-1:0] mgmt_addr_i,
    input wire logic mgmt_rd_i,
    input wire logic mgmt_wr_i,
    input wire logic [DATA_W-1:0] mgmt_wdata_i,
    output logic [DATA_W-1:0] mgmt_rdata_o,
    output logic mgmt_rvalid_o,
    output logic mgmt_hit_o,
    // arbitration side
    input wire logic page_rx_strobe_i,
    input wire logic page_is_base_i,
    input wire logic [DATA_W-1:0] page_word_i,
    input wire logic base_page_i,
    input wire logic par_det_fault_i,
    input wire logic lp_np_able_i,
    input wire logic lp_an_able_i,
    input wire logic mr_page_rx_i,
    input wire logic transmit_disable_i,
    input wire logic alt_next_page_feature_i,
    // next page word toward register 8
    output logic [DATA_W-1:0] np_rx_word_o,
    output logic np_rx_load_o,
    // decoded partner status
    output logic [1:0] lp_selector_kind_o,
    output logic lp_pause_o
);
    // ==================================================================
    // helpers
    function automatic logic is_mine(input logic [ADDR_W-1:0] addr);
        is_mine = (addr == ADDR_PARTNER_BASE) || (addr == ADDR_EXPANSION);
    endfunction

    function automatic sel_kind_t classify_sel(input logic [SEL_W-1:0] sel);
        if (sel == SEL_8023)
            classify_sel = SEL_KIND_8023;
        else if (sel == SEL_8029)
            classify_sel = SEL_KIND_8029;
        else if ((sel == SEL_RSVD_LO) || (sel == SEL_RSVD_HI))
            classify_sel = SEL_KIND_RSVD;
        else
            classify_sel = SEL_KIND_OTHER;
    endfunction

    // ==================================================================
    // partner base page store
    logic [DATA_W-1:0] base_page_reg;
    logic [DATA_W-1:0] base_page_next;
    logic base_load;
    logic next_load;

    assign base_load = page_rx_strobe_i && page_is_base_i;
    assign next_load = page_rx_strobe_i && !page_is_base_i;

    // capture whole code word, reserved bit forced low
    always_comb
    begin
        base_page_next = base_page_reg;
        if (base_load)
            base_page_next = page_word_i & BP_STORE_MASK;
    end

    // fields hold until the next base page arrives
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            base_page_reg <= BP_RESET;
        else
            base_page_reg <= base_page_next;
    end

    // ==================================================================
    // next page hand-off toward register 8
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            np_rx_word_o <= '0;
            np_rx_load_o <= 1'b0;
        end
        else
        begin
            np_rx_load_o <= next_load;
            if (next_load)
                np_rx_word_o <= page_word_i;
        end
    end

    // ==================================================================
    // edge detection for the alternate clear path
    logic page_rx_var_reg;
    logic tx_dis_var_reg;
    logic page_rx_fell;
    logic tx_dis_rose;

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            page_rx_var_reg <= 1'b0;
            tx_dis_var_reg <= 1'b0;
        end
        else
        begin
            page_rx_var_reg <= mr_page_rx_i;
            tx_dis_var_reg <= transmit_disable_i;
        end
    end

    assign page_rx_fell = page_rx_var_reg && !mr_page_rx_i;
    assign tx_dis_rose = !tx_dis_var_reg && transmit_disable_i;

    // ==================================================================
    // latched-high bits
    logic read_exp;
    logic alt_clear;
    logic [LH_COUNT-1:0] lh_set;
    logic [LH_COUNT-1:0] lh_clr;
    logic [LH_COUNT-1:0] lh_q;
    logic [LH_COUNT-1:0] lh_view;

    // a read of the expansion register clears, and the alternate path also clears the page-received bit; a write is not a read
    assign read_exp = mgmt_rd_i && (mgmt_addr_i == ADDR_EXPANSION);
    assign alt_clear = alt_next_page_feature_i && (page_rx_fell || tx_dis_rose);

    assign lh_set[LH_PAR_FAULT] = par_det_fault_i;
    assign lh_set[LH_PAGE_RX] = page_rx_strobe_i;
    assign lh_clr[LH_PAR_FAULT] = read_exp;
    assign lh_clr[LH_PAGE_RX] = read_exp || alt_clear;

    genvar g;
    generate
        for (g = 0; g < LH_COUNT; g++)
        begin : g_lh
            latch_high_bit u_bit
            (
                .core_clk_i(core_clk_i),
                .resetn_i(resetn_i),
                .set_i(lh_set[g]),
                .clr_i(lh_clr[g]),
                .q_o(lh_q[g])
            );
            // a cause present during the read shows as 1
            assign lh_view[g] = lh_q[g] | lh_set[g];
        end
    endgenerate

    // ==================================================================
    // expansion word as seen by a read
    logic [DATA_W-1:0] exp_word;

    always_comb
    begin
        exp_word = EX_RESET;
        exp_word[EX_BASE_PAGE] = alt_next_page_feature_i & base_page_i;
        exp_word[EX_PAR_FAULT] = lh_view[LH_PAR_FAULT];
        exp_word[EX_LP_NP_ABLE] = lp_np_able_i;
        exp_word[EX_NP_ABLE] = LOCAL_NP_ABLE;
        exp_word[EX_PAGE_RX] = lh_view[LH_PAGE_RX];
        exp_word[EX_LP_AN_ABLE] = lp_an_able_i;
    end

    // ==================================================================
    // read data path
    logic [DATA_W-1:0] rdata_next;

    // writes are decoded but never steer any storage
    always_comb
    begin
        rdata_next = '0;
        if (mgmt_addr_i == ADDR_PARTNER_BASE)
            rdata_next = base_page_reg;
        else if (mgmt_addr_i == ADDR_EXPANSION)
            rdata_next = exp_word;
    end

    // read answers one cycle after the strobe
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mgmt_rdata_o <= '0;
            mgmt_rvalid_o <= 1'b0;
            mgmt_hit_o <= 1'b0;
        end
        else
        begin
            mgmt_rvalid_o <= mgmt_rd_i && is_mine(mgmt_addr_i);
            mgmt_hit_o <= (mgmt_rd_i || mgmt_wr_i) && is_mine(mgmt_addr_i);
            if (mgmt_rd_i && is_mine(mgmt_addr_i))
                mgmt_rdata_o <= rdata_next;
        end
    end

    // ==================================================================
    // decoded partner status
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            lp_selector_kind_o <= SEL_KIND_RSVD;
            lp_pause_o <= 1'b0;
        end
        else
        begin
            lp_selector_kind_o <= classify_sel(base_page_next[BP_SEL_MSB:BP_SEL_LSB]);
            lp_pause_o <= base_page_next[BP_PAUSE] | base_page_next[BP_ASYM_PAUSE];
        end
    end

    // write data is deliberately unused: both registers are read-only
    logic unused_wdata;
    assign unused_wdata = ^mgmt_wdata_i;
endmodule
`default_nettype wire

// [core/autoneg_regs_pkg.sv]
`default_nettype none
package autoneg_regs_pkg;
    // ==================================================================
    // register map
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [4:0] ADDR_PARTNER_BASE = 5'h05;
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_PARTNER_NEXT = 5'h08;

    // ==================================================================
    // partner base page ability fields
    localparam int BP_NEXT_PAGE = 15;
    localparam int BP_ACK = 14;
    localparam int BP_REMOTE_FAULT = 13;
    localparam int BP_RESERVED = 12;
    localparam int BP_ASYM_PAUSE = 11;
    localparam int BP_PAUSE = 10;
    localparam int BP_T4 = 9;
    localparam int BP_TX_FD = 8;
    localparam int BP_TX_HD = 7;
    localparam int BP_10_FD = 6;
    localparam int BP_10_HD = 5;
    localparam int BP_SEL_MSB = 4;
    localparam int BP_SEL_LSB = 0;
    localparam int SEL_W = 5;
    localparam logic [15:0] BP_RESET = 16'h0000;
    localparam logic [15:0] BP_STORE_MASK = 16'hEFFF;
    localparam logic [4:0] SEL_8023 = 5'h01;
    localparam logic [4:0] SEL_8029 = 5'h02;
    localparam logic [4:0] SEL_RSVD_LO = 5'h00;
    localparam logic [4:0] SEL_RSVD_HI = 5'h1F;

    // ==================================================================
    // expansion fields
    localparam int EX_BASE_PAGE = 5;
    localparam int EX_PAR_FAULT = 4;
    localparam int EX_LP_NP_ABLE = 3;
    localparam int EX_NP_ABLE = 2;
    localparam int EX_PAGE_RX = 1;
    localparam int EX_LP_AN_ABLE = 0;
    localparam logic [15:0] EX_RESET = 16'h0004;
    localparam logic LOCAL_NP_ABLE_RESET = 1'b1;

    // latched-high bit slots
    localparam int LH_COUNT = 2;
    localparam int LH_PAR_FAULT = 0;
    localparam int LH_PAGE_RX = 1;

    // selector classification
    typedef enum logic [1:0] {
        SEL_KIND_RSVD = 2'b00,
        SEL_KIND_8023 = 2'b01,
        SEL_KIND_8029 = 2'b11,
        SEL_KIND_OTHER = 2'b10
    } sel_kind_t;
endpackage
`default_nettype wire

// [core/latch_high_bit.sv]
`default_nettype none
module latch_high_bit
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);
    // ==================================================================
    // sticky bit; set beats clear in the same cycle
    logic q_reg;
    logic q_next;

    always_comb
    begin
        q_next = q_reg;
        if (clr_i)
            q_next = 1'b0;
        if (set_i)
            q_next = 1'b1;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            q_reg <= 1'b0;
        else
            q_reg <= q_next;
    end

    assign q_o = q_reg;
endmodule
`default_nettype wire

// [tb/mgmt_master_model.sv]
`default_nettype none
module mgmt_master_model
    import autoneg_regs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [DATA_W-1:0] rdata_i,
    input wire logic rvalid_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [DATA_W-1:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {addr_o, rd_o, wr_o, wdata_o} = '0;
    end
    // one access: strobe over the taking edge, answer sampled one cycle on
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        output logic [DATA_W-1:0] q, output logic ok);
        @(negedge core_clk_i);
        addr_o = a;
        wdata_o = d;
        rd_o = !w;
        wr_o = w;
        @(negedge core_clk_i);
        ok = rvalid_i;
        q = rdata_i;
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~a; // released lines do not keep the old value
        wdata_o = ~d;
    endtask
endmodule
`default_nettype wire

// [tb/anx_regs_chk.sv]
`default_nettype none
module anx_regs_chk
    import autoneg_regs_pkg::*;
(
    input wire logic core_clk_i, resetn_i, mgmt_rd_i, mgmt_wr_i, mgmt_rvalid_o, np_rx_load_o,
    input wire logic page_rx_strobe_i, page_is_base_i, base_page_i, par_det_fault_i,
    input wire logic lp_np_able_i, lp_an_able_i, alt_next_page_feature_i,
    input wire logic [ADDR_W-1:0] mgmt_addr_i,
    input wire logic [DATA_W-1:0] mgmt_rdata_o, page_word_i, np_rx_word_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic rd5, rd6;
    // reads of the two registers
    assign rd5 = mgmt_rd_i && mgmt_addr_i == ADDR_PARTNER_BASE;
    assign rd6 = mgmt_rd_i && mgmt_addr_i == ADDR_EXPANSION;
    // ==========================================================
    // properties
    property p_bp_store;
        page_rx_strobe_i && page_is_base_i ##1 !page_rx_strobe_i ##1 rd5
            |=> mgmt_rdata_o == ($past(page_word_i, 3) & BP_STORE_MASK);
    endproperty
    a_bp_store: assert property (p_bp_store) else $error("base page misstored");
    property p_np_route;
        page_rx_strobe_i && !page_is_base_i |=> np_rx_load_o && np_rx_word_o == $past(page_word_i);
    endproperty
    a_np_route: assert property (p_np_route) else $error("next page not routed");
    property p_pf_hold;
        par_det_fault_i ##1 !rd6 ##1 rd6 |=> mgmt_rdata_o[EX_PAR_FAULT];
    endproperty
    a_pf_hold: assert property (p_pf_hold) else $error("fault not latched");
    property p_pf_clr;
        rd6 && !par_det_fault_i ##1 !par_det_fault_i ##1 rd6 && !par_det_fault_i |=> !mgmt_rdata_o[EX_PAR_FAULT];
    endproperty
    a_pf_clr: assert property (p_pf_clr) else $error("fault not cleared");
    property p_pr_set;
        page_rx_strobe_i ##1 !rd6 ##1 rd6 && !alt_next_page_feature_i |=> mgmt_rdata_o[EX_PAGE_RX];
    endproperty
    a_pr_set: assert property (p_pr_set) else $error("page flag not set");
    property p_pr_clr;
        rd6 && !page_rx_strobe_i ##1 !page_rx_strobe_i ##1 rd6 && !page_rx_strobe_i |=> !mgmt_rdata_o[EX_PAGE_RX];
    endproperty
    a_pr_clr: assert property (p_pr_clr) else $error("page flag not cleared");
    property p_ex_fields;
        rd6 |=> mgmt_rdata_o[15:6] == 10'h000 && mgmt_rdata_o[EX_BASE_PAGE] == $past(base_page_i &&
            alt_next_page_feature_i) && mgmt_rdata_o[EX_LP_NP_ABLE] == $past(lp_np_able_i) &&
            mgmt_rdata_o[EX_NP_ABLE] && mgmt_rdata_o[EX_LP_AN_ABLE] == $past(lp_an_able_i);
    endproperty
    a_ex_fields: assert property (p_ex_fields) else $error("expansion field wrong");
    property p_refuse;
        mgmt_wr_i || mgmt_rd_i && !rd5 && !rd6 |=> !mgmt_rvalid_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused access answered");
    // main scenarios
    c_fault: cover property (par_det_fault_i && rd6);
    c_np: cover property (np_rx_load_o);
    c_wr: cover property (mgmt_wr_i && rd5 == 1'b0);
endmodule
bind autoneg_partner_ability_expansion_regs anx_regs_chk anx_regs_chk_inst (.core_clk_i, .resetn_i,
    .mgmt_rd_i, .mgmt_wr_i, .mgmt_rvalid_o, .np_rx_load_o, .page_rx_strobe_i, .page_is_base_i,
    .base_page_i, .par_det_fault_i, .lp_np_able_i, .lp_an_able_i, .alt_next_page_feature_i,
    .mgmt_addr_i, .mgmt_rdata_o, .page_word_i, .np_rx_word_o);
`default_nettype wire

// [tb/autoneg_partner_ability_expansion_regs_tb_top.sv]
`default_nettype none
module autoneg_partner_ability_expansion_regs_tb_top
    import autoneg_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [15:0] w; logic [15:0] r; logic [1:0] k; logic p;} row_t;
    logic core_clk_i = 0, resetn_i = 0, rd, wr, strb = 0, base = 0, bp = 0, pf = 0, lpnp = 0, lpan = 0;
    logic mrpr = 0, txd = 0, alt = 0, rv, ld, pause, ok, hit;
    logic [4:0] addr;
    logic [1:0] kind;
    logic [15:0] word = 16'h0000, wd, rdat, npw, q;
    int err_total = 0, n_tests = 0, cyc = 0;
    row_t rows [6] = '{'{16'hFFE1, 16'hEFE1, 2'h1, 1'h1}, '{16'h0002, 16'h0002, 2'h3, 1'h0},
        '{16'h0C00, 16'h0C00, 2'h0, 1'h1}, '{16'h401F, 16'h401F, 2'h0, 1'h0},
        '{16'h8803, 16'h8803, 2'h2, 1'h1}, '{16'h03E1, 16'h03E1, 2'h1, 1'h0}};
    autoneg_partner_ability_expansion_regs autoneg_partner_ability_expansion_regs_inst (.core_clk_i, .resetn_i,
        .mgmt_addr_i(addr), .mgmt_rd_i(rd), .mgmt_wr_i(wr), .mgmt_wdata_i(wd), .mgmt_rdata_o(rdat),
        .mgmt_rvalid_o(rv), .mgmt_hit_o(hit), .page_rx_strobe_i(strb), .page_is_base_i(base), .page_word_i(word),
        .base_page_i(bp), .par_det_fault_i(pf), .lp_np_able_i(lpnp), .lp_an_able_i(lpan), .mr_page_rx_i(mrpr),
        .transmit_disable_i(txd), .alt_next_page_feature_i(alt), .np_rx_word_o(npw), .np_rx_load_o(ld),
        .lp_selector_kind_o(kind), .lp_pause_o(pause));
    mgmt_master_model mgmt_master_model_inst (.core_clk_i, .rdata_i(rdat), .rvalid_i(rv), .addr_o(addr),
        .rd_o(rd), .wr_o(wr), .wdata_o(wd));
    // clock and hang guard
    initial
    begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            results();
        end
    end
    // ==========================================================
    // helpers
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] e, input logic v);
        mgmt_master_model_inst.xfer(w, a, 16'hFFFF, q, ok);
        chk({15'h0000, ok}, {15'h0000, v});
        chk({15'h0000, hit}, {15'h0000, (a == ADDR_PARTNER_BASE) || (a == ADDR_EXPANSION)});
        if (v)
            chk(q, e);
    endtask
    task automatic page(input logic b, input logic [15:0] w);
        @(negedge core_clk_i);
        word = w;
        base = b;
        strb = 1;
        @(negedge core_clk_i);
        strb = 0;
    endtask
    task automatic results();
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (10) @(negedge core_clk_i);
        resetn_i = 1;
        foreach (rows[i])
        begin
            page(1'b1, rows[i].w);
            acc(1'b0, ADDR_PARTNER_BASE, rows[i].r, 1'b1);
            chk({14'h0000, kind}, {14'h0000, rows[i].k});
            chk({15'h0000, pause}, {15'h0000, rows[i].p});
        end
        page(1'b0, 16'h1234);
        chk({ld, npw}, {1'b1, 16'h1234});
        acc(1'b0, ADDR_EXPANSION, 16'h0006, 1'b1);
        acc(1'b0, ADDR_EXPANSION, 16'h0004, 1'b1);
        acc(1'b0, ADDR_PARTNER_BASE, rows[5].r, 1'b1);
        @(negedge core_clk_i);
        pf = 1;
        @(negedge core_clk_i);
        pf = 0;
        acc(1'b0, ADDR_EXPANSION, 16'h0014, 1'b1);
        acc(1'b0, ADDR_EXPANSION, 16'h0004, 1'b1);
        pf = 1;
        acc(1'b0, ADDR_EXPANSION, 16'h0014, 1'b1);
        acc(1'b0, ADDR_EXPANSION, 16'h0014, 1'b1);
        pf = 0;
        for (int a = 5; a < 8; a++)
            acc(1'b1, 5'(a), 16'h0000, 1'b0);
        acc(1'b0, 5'h07, 16'h0000, 1'b0);
        acc(1'b0, ADDR_EXPANSION, 16'h0014, 1'b1);
        acc(1'b0, ADDR_PARTNER_BASE, rows[5].r, 1'b1);
        {alt, bp, lpnp, lpan, mrpr} = 5'h1F;
        page(1'b1, rows[0].w);
        mrpr = 0;
        acc(1'b0, ADDR_EXPANSION, 16'h002D, 1'b1);
        page(1'b0, 16'h0000);
        txd = 1;
        acc(1'b0, ADDR_EXPANSION, 16'h002D, 1'b1);
        {alt, bp, lpnp, lpan, txd} = 5'h00;
        resetn_i = 0;
        repeat (2) @(negedge core_clk_i);
        resetn_i = 1;
        acc(1'b0, ADDR_PARTNER_BASE, 16'h0000, 1'b1);
        acc(1'b0, ADDR_EXPANSION, 16'h0004, 1'b1);
        results();
    end
endmodule
`default_nettype wire
